// ---- shared/mii_switch_pkg.sv ----
// Constants for the MII port switch controller.
// Assumes a 25 MHz system clock and a device with a 2-bit clock source selector.
package mii_switch_pkg;

	// ==========================================================
	// Clock and timing
	localparam int        CLK_PERIOD_NS = 40;
	localparam int        MIN_CLK_EDGES = 5;
	localparam int        CLK_IDLE_NS   = 4000;
	// The first edge only opens the count: five whole periods need six edges
	localparam logic [2:0] EDGE_TARGET  = 3'(MIN_CLK_EDGES + 1);
	localparam logic [6:0] IDLE_CYC     =
		7'((CLK_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================================
	// Device clock source selector codes
	localparam logic [1:0] CLK_SEL_INT = 2'h0;
	localparam logic [1:0] CLK_SEL_EXT = 2'h1;
	localparam logic [1:0] CLK_SEL_DIS = 2'h2;

	// ==========================================================
	// Register map (byte offsets) and fields
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam int CTRL_TARGET_BIT = 0;
	localparam int CTRL_START_BIT  = 1;
	localparam int CTRL_MGMT_BIT   = 2;
	localparam int CTRL_RUN_BIT    = 3;

	// ==========================================================
	// Sequencer states
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_WAIT_TX = 6'h02,
		ST_WAIT_RX = 6'h04,
		ST_WAIT_OFF = 6'h08,
		ST_SET_CLK = 6'h10,
		ST_WAIT_ON = 6'h20
	} seq_e;

endpackage

// ---- hw/mii_port_switch.sv ----
// Host-side sequencer that switches the device's MII between internal and external PHY.
// Assumes device management busy, halt status and MII clocks arrive asynchronously.
module mii_port_switch
	import mii_switch_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        int_tx_clk,
	input  wire logic        int_rx_clk,
	input  wire logic        ext_tx_clk,
	input  wire logic        ext_rx_clk,
	input  wire logic        tx_halted,
	input  wire logic        rx_halted,
	input  wire logic        mgmt_busy,
	output logic [1:0]       clk_source_select,
	output logic             mii_signal_port_select,
	output logic             management_port_select,
	output logic             tx_enable,
	output logic             rx_enable
);

	// ==========================================================
	// State
	typedef struct packed {
		seq_e            st;
		logic [6:0]      sync1;
		logic [6:0]      sync2;
		logic [3:0]      clk_prev;
		logic [3:0][2:0] edges;
		logic [3:0][6:0] idle;
		logic            target;
		logic            run;
		logic            mgmt_want;
		logic [1:0]      clk_sel;
		logic            port_sel;
		logic            mgmt_sel;
		logic            tx_en;
		logic            rx_en;
		logic            wreq;
		logic [31:0]     rdata;
	} state_s;

	state_s      state_r;
	state_s      state_nxt;
	logic [6:0]  async_in;
	logic [3:0]  clk_rise;
	logic        tx_halted_s;
	logic        rx_halted_s;
	logic        mgmt_busy_s;
	logic        ctrl_wr;
	logic        off_settled;
	logic        on_settled;

	// Clock set of one port: internal is bits 1:0, external 3:2
	function automatic logic [3:0] port_mask(input logic ext);
		port_mask = ext ? 4'hc : 4'h3;
	endfunction

	// Every clock in the mask has shown six edges or has stood still
	function automatic logic settled(input logic [3:0] mask,
		input logic [3:0][2:0] e, input logic [3:0][6:0] idl);
		settled = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (mask[i] && e[i] < EDGE_TARGET && idl[i] != IDLE_CYC) begin
				settled = 1'b0;
			end
		end
	endfunction

	assign async_in = {mgmt_busy, rx_halted, tx_halted,
		ext_rx_clk, ext_tx_clk, int_rx_clk, int_tx_clk};
	assign clk_rise    = state_r.sync2[3:0] & ~state_r.clk_prev;
	assign tx_halted_s = state_r.sync2[4];
	assign rx_halted_s = state_r.sync2[5];
	assign mgmt_busy_s = state_r.sync2[6];
	assign ctrl_wr = write && !state_r.wreq && address[3:2] == CTRL_OFS[3:2];

	// Settle results shared by the sequencer and its checks
	assign off_settled = settled(4'hf, state_r.edges, state_r.idle);
	assign on_settled  = settled(port_mask(state_r.port_sel), state_r.edges, state_r.idle);

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		state_nxt.sync1 = async_in;
		state_nxt.sync2 = state_r.sync1;
		state_nxt.clk_prev = state_r.sync2[3:0];

		// Edge and idle counters per MII clock
		for (int i = 0; i < 4; i++) begin
			if (clk_rise[i]) begin
				state_nxt.idle[i] = 7'h00;
				if (state_r.edges[i] != EDGE_TARGET) begin
					state_nxt.edges[i] = state_r.edges[i] + 3'h1;
				end
			end else if (state_r.idle[i] != IDLE_CYC) begin
				state_nxt.idle[i] = state_r.idle[i] + 7'h01;
			end
		end

		// Avalon slave: one wait state per access
		state_nxt.wreq = 1'b1;
		if ((read || write) && state_r.wreq) begin
			state_nxt.wreq = 1'b0;
		end
		if (read && state_r.wreq) begin
			state_nxt.rdata = 32'h0;
			unique case (address[3:2])
				CTRL_OFS[3:2]: begin
					state_nxt.rdata[CTRL_TARGET_BIT] = state_r.target;
					state_nxt.rdata[CTRL_MGMT_BIT]   = state_r.mgmt_want;
					state_nxt.rdata[CTRL_RUN_BIT]    = state_r.run;
				end
				STATUS_OFS[3:2]: begin
					state_nxt.rdata[0]   = state_r.st != ST_IDLE;
					state_nxt.rdata[1]   = state_r.port_sel;
					state_nxt.rdata[3:2] = state_r.clk_sel;
					state_nxt.rdata[4]   = state_r.mgmt_sel;
					state_nxt.rdata[5]   = state_r.tx_en;
					state_nxt.rdata[6]   = state_r.rx_en;
					state_nxt.rdata[7]   = tx_halted_s;
					state_nxt.rdata[8]   = rx_halted_s;
				end
				default: begin
					state_nxt.rdata = 32'h0;
				end
			endcase
		end
		if (ctrl_wr) begin
			state_nxt.mgmt_want = writedata[CTRL_MGMT_BIT];
			state_nxt.run = writedata[CTRL_RUN_BIT];
		end

		// Management select follows only between transactions
		if (!mgmt_busy_s) begin
			state_nxt.mgmt_sel = state_r.mgmt_want;
		end

		unique case (state_r.st)
			ST_IDLE: begin
				if (ctrl_wr && writedata[CTRL_START_BIT]) begin
					// Software has already settled both PHYs over management
					state_nxt.target = writedata[CTRL_TARGET_BIT];
					state_nxt.run = 1'b1;
					state_nxt.tx_en = 1'b0;
					state_nxt.st = ST_WAIT_TX;
				end else if (ctrl_wr) begin
					state_nxt.tx_en = writedata[CTRL_RUN_BIT];
					state_nxt.rx_en = writedata[CTRL_RUN_BIT];
				end
			end
			ST_WAIT_TX: begin
				if (tx_halted_s) begin
					state_nxt.rx_en = 1'b0;
					state_nxt.st = ST_WAIT_RX;
				end
			end
			ST_WAIT_RX: begin
				if (rx_halted_s) begin
					state_nxt.clk_sel = CLK_SEL_DIS;
					state_nxt.edges = '0;
					state_nxt.idle = '0;
					state_nxt.st = ST_WAIT_OFF;
				end
			end
			ST_WAIT_OFF: begin
				// Stopped clocks time out and drop out of the wait
				if (off_settled) begin
					state_nxt.port_sel = state_r.target;
					state_nxt.st = ST_SET_CLK;
				end
			end
			ST_SET_CLK: begin
				state_nxt.clk_sel = state_r.port_sel ? CLK_SEL_EXT : CLK_SEL_INT;
				state_nxt.edges = '0;
				state_nxt.idle = '0;
				state_nxt.st = ST_WAIT_ON;
			end
			ST_WAIT_ON: begin
				if (on_settled) begin
					if (!state_r.tx_en) begin
						state_nxt.tx_en = 1'b1;
					end else begin
						state_nxt.rx_en = 1'b1;
						state_nxt.st = ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= '{st: ST_IDLE, clk_sel: CLK_SEL_INT, wreq: 1'b1, default: '0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign readdata               = state_r.rdata;
	assign waitrequest            = state_r.wreq;
	assign clk_source_select      = state_r.clk_sel;
	assign mii_signal_port_select = state_r.port_sel;
	assign management_port_select = state_r.mgmt_sel;
	assign tx_enable              = state_r.tx_en;
	assign rx_enable              = state_r.rx_en;

	// ==========================================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_start;
		state_r.st == ST_IDLE && ctrl_wr && writedata[CTRL_START_BIT];
	endsequence

	sequence s_halts_done;
		state_r.st == ST_WAIT_RX ##0 rx_halted_s;
	endsequence

	sequence s_off_leave;
		state_r.st == ST_WAIT_OFF ##1 state_r.st == ST_SET_CLK;
	endsequence

	a_mgmt_idle_switch: assert property (
		$changed(state_r.mgmt_sel) |-> !$past(mgmt_busy_s))
		else $error("management select changed while busy");

	a_port_clk_off: assert property (
		$changed(state_r.port_sel) |->
			state_r.clk_sel == CLK_SEL_DIS && $past(state_r.clk_sel) == CLK_SEL_DIS)
		else $error("signal port changed with clocks enabled");

	a_halt_order: assert property (
		$fell(state_r.rx_en) && state_r.st == ST_WAIT_RX |->
			!state_r.tx_en && $past(tx_halted_s))
		else $error("receiver halted before transmitter");

	a_clk_after_halt: assert property (
		s_halts_done |=> state_r.clk_sel == CLK_SEL_DIS && !state_r.tx_en
			&& !state_r.rx_en && state_r.st == ST_WAIT_OFF)
		else $error("clocks not disabled after halts");

	a_off_wait: assert property (
		s_off_leave |-> $past(off_settled)
			&& state_r.clk_sel == CLK_SEL_DIS)
		else $error("clock-off wait cut short");

	a_idle_clock_skip: assert property (
		state_r.st == ST_WAIT_OFF && state_r.idle[3] == IDLE_CYC
			&& state_r.idle[2] == IDLE_CYC && state_r.edges[1] == EDGE_TARGET
			&& state_r.edges[0] == EDGE_TARGET |=> state_r.st == ST_SET_CLK)
		else $error("stopped clocks held the wait");

	a_port_then_clk: assert property (
		$changed(state_r.clk_sel) && state_r.clk_sel != CLK_SEL_DIS |->
			$past(state_r.st) == ST_SET_CLK && state_r.clk_sel ==
			(state_r.port_sel ? CLK_SEL_EXT : CLK_SEL_INT))
		else $error("clock source differs from signal port");

	a_on_wait: assert property (
		$rose(state_r.tx_en) && state_r.st == ST_WAIT_ON |->
			$past(on_settled))
		else $error("transmitter enabled before new clocks settled");

	a_enable_order: assert property (
		$rose(state_r.tx_en) && state_r.st == ST_WAIT_ON |=>
			state_r.rx_en && state_r.st == ST_IDLE)
		else $error("receiver not enabled right after transmitter");

	a_start_full: assert property (
		s_start |=> state_r.st == ST_WAIT_TX && !state_r.tx_en
			&& state_r.target == $past(writedata[CTRL_TARGET_BIT]))
		else $error("switch request did not start the sequence");

	sequence s_halt_pending;
		state_r.st == ST_WAIT_TX && !tx_halted_s;
	endsequence

	sequence s_off_unsettled;
		state_r.st == ST_WAIT_OFF && !off_settled;
	endsequence

	sequence s_on_unsettled;
		state_r.st == ST_WAIT_ON && !on_settled;
	endsequence

	a_rx_waits_tx: assert property (
		s_halt_pending |=> state_r.st == ST_WAIT_TX && $stable(state_r.rx_en))
		else $error("receiver touched before transmitter halt completed");

	a_off_hold: assert property (
		s_off_unsettled |=> state_r.st == ST_WAIT_OFF
			&& state_r.clk_sel == CLK_SEL_DIS && $stable(state_r.port_sel))
		else $error("clock-off wait left before every clock settled");

	a_on_hold: assert property (
		s_on_unsettled |=> state_r.st == ST_WAIT_ON && !state_r.tx_en && !state_r.rx_en)
		else $error("enables raised before new clocks settled");

	a_idle_clk_on: assert property (
		state_r.st == ST_IDLE |-> state_r.clk_sel != CLK_SEL_DIS)
		else $error("sequencer idle with clocks disabled");

	a_clk_matches_port: assert property (
		state_r.clk_sel != CLK_SEL_DIS |->
			state_r.clk_sel == (state_r.port_sel ? CLK_SEL_EXT : CLK_SEL_INT))
		else $error("clock source and signal port disagree");

	a_mgmt_follow: assert property (
		!mgmt_busy_s |=> state_r.mgmt_sel == $past(state_r.mgmt_want))
		else $error("management select did not follow while idle");

	// Any clock short of six edges and not yet timed out keeps the clock-off wait open
	for (genvar g = 0; g < 4; g++) begin : g_clk_chk
		a_clk_holds_off: assert property (
			state_r.st == ST_WAIT_OFF && state_r.edges[g] < EDGE_TARGET
				&& state_r.idle[g] != IDLE_CYC |=> state_r.st == ST_WAIT_OFF)
			else $error("clock-off wait ignored a running clock");
	end

endmodule

// ---- dv/mii_device_model.sv ----
// Device model: PHY clocks, halt status, management busy, MAC clock gate.
// Assumes the controller's pins change on clk edges.
module mii_device_model
	import mii_switch_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       ext_run,
	input  wire logic       mgmt_go,
	input  wire logic [1:0] clk_source_select,
	input  wire logic       tx_enable,
	input  wire logic       rx_enable,
	input  wire logic       mii_signal_port_select,
	output logic            int_clk,
	output logic            ext_clk,
	output logic            tx_halted,
	output logic            rx_halted,
	output logic            mgmt_busy,
	output logic            mac_clk,
	output logic [3:0]      mac_rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] tx_d   = 3'h7;
	logic [2:0] rx_d   = 3'h7;
	int         busy_n = 0;
	logic       ph     = 1'b0;
	logic       ext_on = 1'b0;
	// ======================================
	// PHY clocks, 320 ns, unrelated phases
	initial begin
		int_clk = 1'b0;
		#7;
		forever #160 int_clk = ~int_clk;
	end
	initial begin
		#53;
		forever #160 ph = ~ph;
	end
	// Stopped PHY holds its clock low, gated in the low phase
	always @(negedge ph) ext_on <= ext_run;
	assign ext_clk = ph & ext_on;
	// ======================================
	// Halt completes three cycles after the enable drops
	always @(posedge clk) begin
		tx_d   <= {tx_d[1:0], ~tx_enable};
		rx_d   <= {rx_d[1:0], ~rx_enable};
		busy_n <= mgmt_go ? 20 : (busy_n > 0 ? busy_n - 1 : 0);
	end
	assign tx_halted = tx_d[2] & ~tx_enable;
	assign rx_halted = rx_d[2] & ~rx_enable;
	assign mgmt_busy = busy_n != 0;
	// Clock to MAC logic, held low while disabled
	assign mac_clk = (clk_source_select == CLK_SEL_INT) ? int_clk :
		(clk_source_select == CLK_SEL_EXT) ? ext_clk : 1'b0;
	// Signal mux: each PHY presents its own receive nibble
	assign mac_rxd = mii_signal_port_select ? 4'ha : 4'h5;
endmodule

// ---- dv/tb_mii_port_switch.sv ----
// Self-checking bench for the MII port switch controller.
// Assumes mii_device_model stands for the device.
module tb_mii_port_switch
	import mii_switch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MIN_GAP = MIN_CLK_EDGES * 320 / CLK_PERIOD_NS;
	logic        clk, rst, read, write, ext_run, mgmt_go, waitrequest;
	logic [3:0]  address, mac_rxd;
	logic [31:0] writedata, readdata;
	logic        int_clk, ext_clk, tx_halted, rx_halted, mgmt_busy, mac_clk;
	logic [1:0]  clk_source_select, cs_p;
	logic        mii_signal_port_select, management_port_select, tx_enable, rx_enable;
	logic        ps_p, tx_p, rx_p, saw_dis;
	int          gap, compares, miscompares;

	mii_port_switch i_mii_port_switch (
		.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.int_tx_clk(int_clk), .int_rx_clk(int_clk), .ext_tx_clk(ext_clk),
		.ext_rx_clk(ext_clk), .tx_halted, .rx_halted, .mgmt_busy, .clk_source_select,
		.mii_signal_port_select, .management_port_select, .tx_enable, .rx_enable);
	mii_device_model i_mii_device_model (
		.clk, .ext_run, .mgmt_go, .clk_source_select, .tx_enable, .rx_enable,
		.int_clk, .ext_clk, .tx_halted, .rx_halted, .mgmt_busy, .mac_clk,
		.mii_signal_port_select, .mac_rxd);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ======================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic stuck;
		miscompares++;
		conclude();
	endtask
	function automatic logic [31:0] exp_status(input logic t, input logic m);
		return {25'h0, 2'h3, m, 1'b0, t, t, 1'b0};
	endfunction
	// ======================================
	// Avalon master access
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		write     <= w;
		read      <= ~w;
		address   <= a;
		writedata <= d;
		@(posedge clk);
		while (waitrequest !== 1'b0) begin
			@(posedge clk);
			n++;
			if (n > 20)
				stuck();
		end
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	// ======================================
	// Order monitor on the device pins
	always @(posedge clk) begin
		gap++;
		if (!rst && clk_source_select !== cs_p) begin
			gap = 0;
			if (clk_source_select === CLK_SEL_DIS) begin
				saw_dis = 1'b1;
				check(tx_halted & rx_halted & ~tx_p & ~rx_p, 1'b1);
			end else
				check(clk_source_select, {1'b0, mii_signal_port_select});
		end
		if (!rst && mii_signal_port_select !== ps_p) begin
			check({cs_p, clk_source_select}, {CLK_SEL_DIS, CLK_SEL_DIS});
			check(gap >= MIN_GAP, 1'b1);
		end
		if (!rst && saw_dis && rx_enable !== rx_p)
			check(rx_enable ? tx_p : (tx_halted & ~tx_enable), 1'b1);
		if (!rst && saw_dis && tx_enable === 1'b1 && tx_p === 1'b0)
			check(clk_source_select !== CLK_SEL_DIS && gap >= MIN_GAP, 1'b1);
		if (!rst && clk_source_select === CLK_SEL_DIS && cs_p === CLK_SEL_DIS)
			check(mac_clk, 1'b0);
		cs_p = clk_source_select;
		ps_p = mii_signal_port_select;
		tx_p = tx_enable;
		rx_p = rx_enable;
	end
	// ======================================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic        t, m;
		int          n;
		{rst, read, write, address, writedata, ext_run, mgmt_go} = {3'h4, 36'h0, 2'h2};
		{cs_p, ps_p, tx_p, rx_p, saw_dis, gap, compares, miscompares} = '0;
		void'($urandom(5));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, 4'h8, 32'h0, q);
		check(q, 32'h0);
		bus(1'b1, CTRL_OFS, 32'h8, q);
		mgmt_go <= 1'b1;
		@(posedge clk);
		mgmt_go <= 1'b0;
		repeat (3) @(posedge clk);
		bus(1'b1, CTRL_OFS, 32'hc, q);
		repeat (4) @(posedge clk);
		check(management_port_select, 1'b0);
		repeat (20) @(posedge clk);
		check(management_port_select, 1'b1);
		for (int k = 0; k < 7; k++) begin
			t = (k < 3) ? (k == 0) : 1'($urandom);
			m = 1'($urandom);
			// Third switch runs with the deselected external clock stopped
			ext_run <= t | mii_signal_port_select | (k != 2 && 1'($urandom));
			repeat (20) @(posedge clk);
			saw_dis = 1'b0;
			mgmt_go <= 1'($urandom);
			bus(1'b1, CTRL_OFS, {28'h0, 1'b1, m, 1'b1, t}, q);
			mgmt_go <= 1'b0;
			n = 0;
			q = 32'h1;
			while (q[0] !== 1'b0) begin
				bus(1'b0, STATUS_OFS, 32'h0, q);
				n++;
				if (n > 300)
					stuck();
			end
			check(saw_dis, 1'b1);
			repeat (10) @(posedge clk);
			bus(1'b0, STATUS_OFS, 32'h0, q);
			check(q, exp_status(t, m));
			check(mac_rxd, t ? 4'ha : 4'h5);
		end
		conclude();
	end
endmodule
